// >>> verilog/voice_message_command_handler.sv
// Command interpreter for message, synthesis and speed commands
`timescale 1ns/1ps
`include "vmch_consts.svh"

// What this block does
// - Line config command 0x38 takes one byte; every byte is echoed.
// - Line value 1 turns channel one off; value 3 turns it on.
// - With channel one on, recording sums both channels into one stream.
// - Playback goes to all active channels; channel zero always active.
// - Pointer command 0x30 sets pointer to page count times 32.
// - Pointer in idle opens the message; halt later closes it.
// - Offset past message end: completion event, pointer at end, idle.
// - Pointer and tag commands flag invalid context without a message.
// - Tag write command 0x05 applies two-byte tag to current message.
// - Tag write only clears bits; written ones are ignored.
// - Word command 0x07 plays indexed word and enters synthesis.
// - Word or sentence end: completion event, attention request, idle.
// - Undefined word or control code index sets bad argument.
// - Word and sentence flag invalid context without vocabulary.
// - Speed command 0x16 takes -6 to +6; others set bad argument.
// - Negative speed is faster, positive slower, monotonic.
// - Speed persists until changed and affects current playback.
// - Speed has no effect on uncompressed PCM data.
// - Sentence command 0x1F plays sentence; its argument is zero.
// - Undefined sentence index sets bad argument.
// - Skip command 0x22 takes two bytes, echoed; playback then pauses.
// - Halt command 0x00 aborts and returns to idle.
// - Skip length in 0.2 s units, at most 320, else bad argument.
module voice_message_command_handler #(
	parameter int PTR_W = 21,
	parameter logic [7:0] CTRL_CODE_BASE = 8'hF0
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Message store
	input wire logic msgDefined,
	input wire logic [PTR_W-1:0] msgLength,
	input wire logic [15:0] msgTag,
	input wire logic msgIsPcm,
	output logic [PTR_W-1:0] msgPointer,
	output logic tagWrite,
	output logic [15:0] tagValue,
	// Vocabulary and synthesis engine
	input wire logic vocabSelected,
	input wire logic [7:0] wordCount,
	input wire logic [7:0] sentenceCount,
	input wire logic synthDone,
	output logic synthStart,
	output logic synthIsSentence,
	output logic [7:0] synthIndex,
	output logic [7:0] synthArg,
	// Playback engine
	input wire logic playStart,
	input wire logic skipHitEnd,
	output logic skipStart,
	output logic [15:0] skipLength,
	output logic playPaused,
	output logic [7:0] speedOut,
	output logic abortCmd,
	// Line channels
	input wire vmch_pkg::line_pair_s lineIn,
	input wire logic [15:0] playSample,
	output logic [16:0] recSample,
	output vmch_pkg::line_pair_s lineOut,
	output logic ch1Active,
	// Host
	output logic hostAttention,
	output vmch_pkg::dev_state_e devState
);

	// ==========================================================
	// Bus slave
	logic awHeld, wHeld;
	logic [7:0] awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0] wStrbQ;

	wire awFire = awvalid & awready;
	wire wFire = wvalid & wready;
	wire arFire = arvalid & arready;
	wire doWrite = awHeld & wHeld & ~bvalid;
	wire next_awHeld = ~doWrite & (awHeld | awFire);
	wire next_wHeld = ~doWrite & (wHeld | wFire);
	wire next_bvalid = doWrite | (bvalid & ~bready);
	wire next_rvalid = arFire | (rvalid & ~rready);

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `VMCH_OFF_CMD) || (a == `VMCH_OFF_ECHO) ||
			(a == `VMCH_OFF_STATUS) || (a == `VMCH_OFF_CONFIG) ||
			(a == `VMCH_OFF_POINTER) || (a == `VMCH_OFF_TAG);
	endfunction

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 8'h00;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `VMCH_RESP_OKAY;
		end else if (ce) begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			if (awFire) begin
				awAddrQ <= awaddr;
			end
			if (wFire) begin
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			awready <= ~next_awHeld & ~next_bvalid;
			wready <= ~next_wHeld & ~next_bvalid;
			bvalid <= next_bvalid;
			if (doWrite) begin
				bresp <= mapped(awAddrQ) ? `VMCH_RESP_OKAY :
					`VMCH_RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Command byte parser
	vmch_pkg::parse_state_e pState;
	logic [7:0] opcode, firstByte, echoByte;
	logic [1:0] remain;
	logic echoValid;
	vmch_pkg::flags_s flags;

	function automatic logic [1:0] paramCount(input logic [7:0] op);
		case (op)
		`VMCH_OP_LINE_CFG, `VMCH_OP_WORD, `VMCH_OP_SPEED,
		`VMCH_OP_SENTENCE: paramCount = 2'd1;
		`VMCH_OP_MSG_PTR, `VMCH_OP_TAG_WR, `VMCH_OP_SKIP:
			paramCount = 2'd2;
		default: paramCount = 2'd0;
		endcase
	endfunction

	wire byteIn = doWrite & (awAddrQ == `VMCH_OFF_CMD) & wStrbQ[0];
	wire [7:0] byteVal = wDataQ[7:0];
	wire isOpByte = (pState == vmch_pkg::P_OPCODE);
	wire [1:0] opParams = paramCount(byteVal);
	wire lastByte = byteIn & (isOpByte ? (opParams == 2'd0) :
		(remain == 2'd1));
	wire [7:0] curOp = isOpByte ? byteVal : opcode;
	wire [7:0] arg8 = byteVal;
	wire [15:0] arg16 = {firstByte, byteVal};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pState <= vmch_pkg::P_OPCODE;
			opcode <= `VMCH_RST_BYTE;
			firstByte <= `VMCH_RST_BYTE;
			remain <= 2'd0;
			echoByte <= `VMCH_RST_BYTE;
			echoValid <= 1'b0;
		end else if (ce && byteIn) begin
			echoByte <= byteVal;
			echoValid <= 1'b1;
			if (lastByte) begin
				pState <= vmch_pkg::P_OPCODE;
			end else if (isOpByte) begin
				pState <= vmch_pkg::P_PARAM;
				opcode <= byteVal;
				remain <= opParams;
			end else begin
				firstByte <= byteVal;
				remain <= remain - 2'd1;
			end
		end
	end

	// ==========================================================
	// Command decode
	wire exec = lastByte;
	wire isIdle = (devState == vmch_pkg::ST_IDLE);
	wire [PTR_W-1:0] reqOffset =
		PTR_W'({5'h00, arg16} << `VMCH_PAGE_SHIFT);
	wire pastEnd = reqOffset > msgLength;
	wire signed [7:0] speedArg = arg8;
	wire speedOk = (speedArg >= $signed(`VMCH_SPEED_MIN)) &&
		(speedArg <= $signed(`VMCH_SPEED_MAX));
	wire wordOk = (arg8 < wordCount) && (arg8 < CTRL_CODE_BASE);
	wire sentOk = arg8 < sentenceCount;
	wire lineOk = (arg8 == `VMCH_LINE_ONE) || (arg8 == `VMCH_LINE_BOTH);

	wire doHalt = exec & (curOp == `VMCH_OP_HALT);
	wire doLine = exec & (curOp == `VMCH_OP_LINE_CFG);
	wire doPtr = exec & (curOp == `VMCH_OP_MSG_PTR);
	wire doTag = exec & (curOp == `VMCH_OP_TAG_WR);
	wire doWord = exec & (curOp == `VMCH_OP_WORD);
	wire doSpeed = exec & (curOp == `VMCH_OP_SPEED);
	wire doSent = exec & (curOp == `VMCH_OP_SENTENCE);
	wire doSkip = exec & (curOp == `VMCH_OP_SKIP);

	wire ptrGo = doPtr & msgDefined;
	wire tagGo = doTag & msgDefined;
	wire wordGo = doWord & vocabSelected & wordOk;
	wire sentGo = doSent & vocabSelected & sentOk;
	wire skipOk = arg16 <= `VMCH_SKIP_MAX;
	wire skipGo = doSkip & skipOk & (devState == vmch_pkg::ST_PLAY);
	wire synthEnd = synthDone & (devState == vmch_pkg::ST_SYNTH);
	wire playEndHit = skipHitEnd & (devState == vmch_pkg::ST_PLAY);

	// ==========================================================
	// Sticky flags, set wins over software clear
	wire statusClr = doWrite & (awAddrQ == `VMCH_OFF_STATUS) & wStrbQ[0];
	wire [2:0] clrMask = statusClr ?
		{wDataQ[`VMCH_ST_INVALID_CTX], wDataQ[`VMCH_ST_BAD_ARG],
		wDataQ[`VMCH_ST_NORMAL_END]} : 3'b000;
	wire setInvalid = (doPtr & ~msgDefined) | (doTag & ~msgDefined) |
		((doWord | doSent) & ~vocabSelected);
	wire setBadArg = (doSpeed & ~speedOk) | (doLine & ~lineOk) |
		(doSkip & ~skipOk) | (doWord & vocabSelected & ~wordOk) |
		(doSent & vocabSelected & ~sentOk);
	wire setNormal = synthEnd | (ptrGo & pastEnd) | playEndHit;
	wire [2:0] next_flags = (flags & ~clrMask) |
		{setInvalid, setBadArg, setNormal};

	// ==========================================================
	// Device state
	vmch_pkg::dev_state_e next_state;
	always_comb begin
		next_state = devState;
		case (devState)
		vmch_pkg::ST_IDLE: begin
			if (ptrGo && !pastEnd) begin
				next_state = vmch_pkg::ST_MESSAGE_OPENED_STATE;
			end else if (wordGo || sentGo) begin
				next_state = vmch_pkg::ST_SYNTH;
			end else if (playStart) begin
				next_state = vmch_pkg::ST_PLAY;
			end
		end
		vmch_pkg::ST_MESSAGE_OPENED_STATE: begin
			if (ptrGo && pastEnd) begin
				next_state = vmch_pkg::ST_IDLE;
			end
		end
		vmch_pkg::ST_SYNTH: begin
			if (synthEnd) begin
				next_state = vmch_pkg::ST_IDLE;
			end
		end
		vmch_pkg::ST_PLAY: begin
			if (playEndHit) begin
				next_state = vmch_pkg::ST_IDLE;
			end
		end
		default: next_state = vmch_pkg::ST_IDLE;
		endcase
		if (doHalt) begin
			next_state = vmch_pkg::ST_IDLE;
		end
	end

	// ==========================================================
	// Command effects
	logic signed [7:0] speedSet;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			devState <= vmch_pkg::ST_IDLE;
			flags <= 3'b000;
			ch1Active <= 1'b0;
			msgPointer <= '0;
			speedSet <= `VMCH_RST_SPEED;
			tagValue <= 16'h0000;
			tagWrite <= 1'b0;
			synthStart <= 1'b0;
			synthIsSentence <= 1'b0;
			synthIndex <= `VMCH_RST_BYTE;
			synthArg <= `VMCH_RST_BYTE;
			skipStart <= 1'b0;
			skipLength <= 16'h0000;
			playPaused <= 1'b0;
			abortCmd <= 1'b0;
		end else if (ce) begin
			devState <= next_state;
			flags <= next_flags;
			tagWrite <= tagGo;
			synthStart <= (wordGo | sentGo) & isIdle;
			skipStart <= skipGo;
			abortCmd <= doHalt;
			if (doLine && lineOk) begin
				ch1Active <= (arg8 == `VMCH_LINE_BOTH);
			end
			if (ptrGo) begin
				msgPointer <= pastEnd ? msgLength : reqOffset;
			end
			if (tagGo) begin
				tagValue <= msgTag & arg16;
			end
			if (doSpeed && speedOk) begin
				speedSet <= speedArg;
			end
			if ((wordGo || sentGo) && isIdle) begin
				synthIsSentence <= sentGo;
				synthIndex <= arg8;
				synthArg <= `VMCH_SENT_ARG;
			end
			if (skipGo) begin
				skipLength <= arg16;
			end
			if (skipGo) begin
				playPaused <= 1'b1;
			end else if (next_state != vmch_pkg::ST_PLAY) begin
				playPaused <= 1'b0;
			end
		end
	end

	// Attention follows the pending completion event
	assign hostAttention = flags.normalEnd;

	// ==========================================================
	// Speed and line datapath
	// Speed is passed as a signed step; the decoder maps lower to faster
	wire [7:0] next_speed = msgIsPcm ? `VMCH_RST_SPEED : speedSet;
	wire [16:0] sumRec = {lineIn.line0[15], lineIn.line0} +
		{lineIn.line1[15], lineIn.line1};
	wire [16:0] next_rec = ch1Active ? sumRec :
		{lineIn.line0[15], lineIn.line0};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			speedOut <= `VMCH_RST_SPEED;
			recSample <= 17'h0_0000;
			lineOut <= 32'h0000_0000;
		end else if (ce) begin
			speedOut <= next_speed;
			recSample <= next_rec;
			lineOut.line0 <= playSample;
			lineOut.line1 <= ch1Active ? playSample : 16'h0000;
		end
	end

	// ==========================================================
	// Register read path
	wire [31:0] statusWord = {22'h00_0000, devState, 3'b000,
		playPaused, echoValid, flags};
	wire [31:0] configWord = {16'h0000, speedSet, 7'h00, ch1Active};
	wire [31:0] readMux =
		(araddr == `VMCH_OFF_ECHO) ? {24'h00_0000, echoByte} :
		(araddr == `VMCH_OFF_STATUS) ? statusWord :
		(araddr == `VMCH_OFF_CONFIG) ? configWord :
		(araddr == `VMCH_OFF_POINTER) ? 32'(msgPointer) :
		(araddr == `VMCH_OFF_TAG) ? {16'h0000, tagValue} :
		32'h0000_0000;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `VMCH_RESP_OKAY;
		end else if (ce) begin
			arready <= ~next_rvalid;
			rvalid <= next_rvalid;
			if (arFire) begin
				rdata <= readMux;
				rresp <= mapped(araddr) ? `VMCH_RESP_OKAY :
					`VMCH_RESP_SLVERR;
			end
		end
	end

endmodule // voice_message_command_handler

// >>> include/vmch_consts.svh
// Offsets, opcodes, field positions and reset values of the command handler
`ifndef VMCH_CONSTS_SVH
`define VMCH_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define VMCH_OFF_CMD 8'h00
`define VMCH_OFF_ECHO 8'h04
`define VMCH_OFF_STATUS 8'h08
`define VMCH_OFF_CONFIG 8'h0C
`define VMCH_OFF_POINTER 8'h10
`define VMCH_OFF_TAG 8'h14

// ==========================================================
// Command opcodes
`define VMCH_OP_HALT 8'h00
`define VMCH_OP_LINE_CFG 8'h38
`define VMCH_OP_MSG_PTR 8'h30
`define VMCH_OP_TAG_WR 8'h05
`define VMCH_OP_WORD 8'h07
`define VMCH_OP_SPEED 8'h16
`define VMCH_OP_SENTENCE 8'h1F
`define VMCH_OP_SKIP 8'h22

// ==========================================================
// Argument values and limits
`define VMCH_LINE_ONE 8'h01
`define VMCH_LINE_BOTH 8'h03
`define VMCH_SPEED_MIN 8'hFA
`define VMCH_SPEED_MAX 8'h06
`define VMCH_SKIP_MAX 16'h0140
`define VMCH_PAGE_SHIFT 5
`define VMCH_SENT_ARG 8'h00

// ==========================================================
// Status word fields
`define VMCH_ST_NORMAL_END 0
`define VMCH_ST_BAD_ARG 1
`define VMCH_ST_INVALID_CTX 2
`define VMCH_ST_ECHO_VALID 3
`define VMCH_ST_PAUSED 4
`define VMCH_ST_STATE_LO 8
`define VMCH_ST_STATE_HI 9

// ==========================================================
// Config word fields and reset values
`define VMCH_CFG_CH1 0
`define VMCH_CFG_SPEED_LO 8
`define VMCH_CFG_SPEED_HI 15
`define VMCH_RST_SPEED 8'h00
`define VMCH_RST_BYTE 8'h00

// ==========================================================
// Bus answers
`define VMCH_RESP_OKAY 2'b00
`define VMCH_RESP_SLVERR 2'b10

`endif

// >>> include/vmch_pkg.sv
// Types shared by the command handler and its bench
package vmch_pkg;

	// ==========================================================
	// Device states, Gray coded along idle-open-synth-play
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MESSAGE_OPENED_STATE = 2'b01,
		ST_SYNTH = 2'b11,
		ST_PLAY = 2'b10
	} dev_state_e;

	typedef enum logic {
		P_OPCODE = 1'b0,
		P_PARAM = 1'b1
	} parse_state_e;

	// ==========================================================
	// Sticky completion and error flags
	typedef struct packed {
		logic invalidCtx;
		logic badArg;
		logic normalEnd;
	} flags_s;

	// Pair of line channel samples
	typedef struct packed {
		logic [15:0] line1;
		logic [15:0] line0;
	} line_pair_s;

endpackage

// >>> dv/vmch_assertions.sv
// Port checks for the command handler
`timescale 1ns/1ps
module vmch_assertions #(
	parameter logic [7:0] CTRL_CODE_BASE = 8'hF0
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// Watched ports
	input wire logic msgIsPcm,
	input wire logic [15:0] msgTag,
	input wire logic tagWrite,
	input wire logic [15:0] tagValue,
	input wire logic [7:0] wordCount,
	input wire logic synthDone,
	input wire logic synthStart,
	input wire logic synthIsSentence,
	input wire logic [7:0] synthIndex,
	input wire logic [7:0] synthArg,
	input wire logic skipStart,
	input wire logic [15:0] skipLength,
	input wire logic playPaused,
	input wire logic [7:0] speedOut,
	input wire logic abortCmd,
	input wire vmch_pkg::line_pair_s lineIn,
	input wire logic [15:0] playSample,
	input wire logic [16:0] recSample,
	input wire vmch_pkg::line_pair_s lineOut,
	input wire logic ch1Active,
	input wire logic hostAttention,
	input wire vmch_pkg::dev_state_e devState
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Helper: expected recording sum
	logic [16:0] sum;
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			sum <= 17'h00000;
		else
			sum <= {lineIn.line0[15], lineIn.line0} +
				{lineIn.line1[15], lineIn.line1};
	sequence s_synth_end;
		ce && synthDone && devState == vmch_pkg::ST_SYNTH;
	endsequence
	sequence s_both_lines;
		ce && ch1Active ##1 ch1Active;
	endsequence
	// ==========================================================
	// Assertions
	a_synth_end: assert property (
		s_synth_end |=> devState == vmch_pkg::ST_IDLE && hostAttention)
		else $error("synthesis end not reported");
	a_synth_start: assert property (
		synthStart |-> devState == vmch_pkg::ST_SYNTH && synthArg == 8'h00)
		else $error("synthesis start wrong");
	a_word_index: assert property (
		synthStart && !synthIsSentence |->
			synthIndex < wordCount && synthIndex < CTRL_CODE_BASE)
		else $error("bad word index played");
	a_pcm_speed: assert property (
		ce && msgIsPcm |=> speedOut == 8'h00)
		else $error("speed applied to pcm");
	a_speed_range: assert property (
		$signed(speedOut) >= -8'sd6 && $signed(speedOut) <= 8'sd6)
		else $error("speed out of range");
	a_skip_limit: assert property (
		skipStart |-> playPaused && skipLength <= 16'h0140 &&
			devState == vmch_pkg::ST_PLAY)
		else $error("skip wrong");
	a_abort_idle: assert property (
		abortCmd |-> devState == vmch_pkg::ST_IDLE && !playPaused)
		else $error("halt did not idle");
	a_tag_clear: assert property (
		tagWrite |-> (tagValue & ~msgTag) == 16'h0000)
		else $error("tag bit set");
	a_play_out: assert property (
		ce |=> lineOut.line0 == $past(playSample))
		else $error("line zero playback wrong");
	a_rec_sum: assert property (
		s_both_lines |-> recSample == sum)
		else $error("recording sum wrong");
	a_play_both: assert property (
		ce |=> lineOut.line1 ==
			($past(ch1Active) ? $past(playSample) : 16'h0000))
		else $error("line one playback wrong");
	a_rec_single: assert property (
		ce && !ch1Active |=>
			recSample == {$past(lineIn.line0[15]), $past(lineIn.line0)})
		else $error("single line recording wrong");
endmodule // vmch_assertions

// >>> dv/vmch_engine_model.sv
// Synthesis engine stand-in, ends each utterance after a lag
`timescale 1ns/1ps
module vmch_engine_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Engine side
	input wire logic synthStart,
	input wire logic [7:0] lag,
	output logic synthDone
);
	logic [7:0] left;
	logic busy;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			left <= 8'h00;
			synthDone <= 1'b0;
		end else begin
			synthDone <= busy && left == 8'h00;
			if (synthStart) begin
				busy <= 1'b1;
				left <= lag;
			end else if (busy && left == 8'h00)
				busy <= 1'b0;
			else if (busy)
				left <= left - 8'h01;
		end
	end
endmodule // vmch_engine_model

// >>> dv/voice_message_command_handler_bench.sv
// Bench driving commands over the register bus
`timescale 1ns/1ps
module voice_message_command_handler_bench;
	// ==========================================================
	// Signals
	logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, lag = 8'h02;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, msgDefined = 1'b0;
	logic msgIsPcm = 1'b0, vocabSelected = 1'b0, synthDone;
	logic playStart = 1'b0, skipHitEnd = 1'b0;
	logic [20:0] msgLength = 21'h000200, msgPointer;
	logic [15:0] msgTag = 16'hF0F0, playSample = 16'h0000;
	logic [7:0] wordCount = 8'hF8, sentenceCount = 8'h04;
	vmch_pkg::line_pair_s lineIn = 32'h0, lineOut;
	logic awready, wready, bvalid, arready, rvalid, tagWrite;
	logic synthStart, synthIsSentence, skipStart, playPaused;
	logic abortCmd, ch1Active, hostAttention;
	logic [1:0] bresp, rresp;
	logic [15:0] tagValue, skipLength;
	logic [7:0] synthIndex, synthArg, speedOut;
	logic [16:0] recSample;
	vmch_pkg::dev_state_e devState;
	logic [31:0] expQ[$];
	int err_total = 0, cmp_count = 0, cyc = 0, i, n;
	integer seed = 55;
	logic [7:0] spd[5] = '{8'hFA, 8'h06, 8'h07, 8'hF9, 8'h00};
	logic [7:0] kept[5] = '{8'hFA, 8'h06, 8'h06, 8'h06, 8'h00};
	// Flags, vocabulary, opcode, index
	logic [19:0] sv[7] = '{20'h107EF, 20'h507F0, 20'h507F8, 20'h11F03,
		20'h51F04, 20'h80700, 20'h81F00};

	voice_message_command_handler i_voice_message_command_handler (.*);
	vmch_engine_model i_vmch_engine_model (.*);

	always #12.5 clk_sys = ~clk_sys;
	// ==========================================================
	// Checking and tasks
	task automatic check(input logic [31:0] got);
		logic [31:0] exp;
		exp = expQ.pop_front();
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		lineIn <= $random(seed);
		playSample <= 16'($random(seed));
		if (bvalid && bready)
			check({30'h0, bresp});
		if (rvalid && rready) begin
			check(rdata);
			check({30'h0, rresp});
		end
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_of_test();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		expQ.push_back({30'h0, r});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		// One idle edge so a following call never re-raises it at once
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		expQ.push_back({30'h0,
			((a <= 8'h14 && a[1:0] == 2'b00) ? 2'b00 : 2'b10)});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic cmd(input logic [7:0] b);
		wr(8'h00, {24'h0, b}, 2'b00);
	endtask
	task automatic st(input logic [2:0] f, input logic p,
		input logic [1:0] s);
		rd(8'h08, {22'h0, s, 3'h0, p, 1'b1, f});
	endtask
	task automatic clr();
		wr(8'h08, 32'h7, 2'b00);
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(8'h08, 32'h0);
		wr(8'h40, 32'h1, 2'b10);
		rd(8'h40, 32'h0);
		cmd(8'h38);
		cmd(8'h03);
		rd(8'h04, 32'h3);
		rd(8'h0C, 32'h1);
		cmd(8'h38);
		cmd(8'h02);
		st(3'h2, 1'b0, 2'h0);
		clr();
		cmd(8'h38);
		cmd(8'h01);
		rd(8'h0C, 32'h0);
		for (i = 0; i < 5; i++) begin
			cmd(8'h16);
			cmd(spd[i]);
			st({1'b0, spd[i] == 8'h07 || spd[i] == 8'hF9, 1'b0},
				1'b0, 2'h0);
			rd(8'h0C, {16'h0, kept[i], 8'h00});
			clr();
		end
		cmd(8'h30);
		cmd(8'h00);
		cmd(8'h01);
		cmd(8'h05);
		cmd(8'h12);
		cmd(8'h34);
		st(3'h4, 1'b0, 2'h0);
		clr();
		msgDefined <= 1'b1;
		cmd(8'h30);
		cmd(8'h00);
		cmd(8'h0A);
		rd(8'h10, 32'h140);
		st(3'h0, 1'b0, 2'h1);
		cmd(8'h30);
		cmd(8'h01);
		cmd(8'h00);
		rd(8'h10, 32'h200);
		st(3'h1, 1'b0, 2'h0);
		clr();
		cmd(8'h30);
		cmd(8'h00);
		cmd(8'h10);
		st(3'h0, 1'b0, 2'h1);
		cmd(8'h00);
		st(3'h0, 1'b0, 2'h0);
		cmd(8'h05);
		cmd(msgTag[15:8] & 8'h0F);
		cmd(msgTag[7:0] | 8'h07);
		rd(8'h14, 32'hF0);
		for (i = 0; i < 7; i++) begin
			vocabSelected <= sv[i][16];
			lag <= 8'($random(seed)) & 8'h3F;
			cmd(sv[i][15:8]);
			cmd(sv[i][7:0]);
			for (n = 0; n < 200 && sv[i][19:17] == 3'h0 &&
				hostAttention !== 1'b1; n++)
				@(posedge clk_sys);
			st(sv[i][19:17] == 3'h0 ? 3'h1 : sv[i][19:17],
				1'b0, 2'h0);
			clr();
		end
		playStart <= 1'b1;
		@(posedge clk_sys);
		playStart <= 1'b0;
		cmd(8'h16);
		cmd(8'hFB);
		rd(8'h0C, 32'hFB00);
		msgIsPcm <= 1'b1;
		cmd(8'h22);
		cmd(8'h01);
		cmd(8'h41);
		st(3'h2, 1'b0, 2'h2);
		cmd(8'h22);
		cmd(8'h01);
		cmd(8'h40);
		st(3'h2, 1'b1, 2'h2);
		msgIsPcm <= 1'b0;
		cmd(8'h00);
		st(3'h2, 1'b0, 2'h0);
		// Enable low: a play start must leave the state untouched
		ce <= 1'b0;
		playStart <= 1'b1;
		@(posedge clk_sys);
		ce <= 1'b1;
		playStart <= 1'b0;
		st(3'h2, 1'b0, 2'h0);
		end_of_test();
	end
endmodule // voice_message_command_handler_bench

bind voice_message_command_handler vmch_assertions #(
	.CTRL_CODE_BASE(CTRL_CODE_BASE)
) i_vmch_assertions (.*);
